// ---- core/sfq_pkg.sv ----
package sfq_pkg;

    // Serial command codes and mode bytes.
    localparam logic [7:0] CMD_RD_SR1 = 8'h05;
    localparam logic [7:0] CMD_RD_SR2 = 8'h35;
    localparam logic [7:0] CMD_WR_SR = 8'h01;
    localparam logic [7:0] CMD_QUAD_RD = 8'heb;
    localparam logic [7:0] CMD_PD_ENTER = 8'hb9;
    localparam logic [7:0] CMD_PD_EXIT = 8'hab;
    localparam logic [7:0] MODE_ENTER = 8'ha5;
    localparam logic [7:0] MODE_EXIT = 8'h00;

    // Status bit positions.
    localparam int SR1_BUSY_BIT = 0;
    localparam int SR2_QE_BIT = 1;

    // Serial clock counts of the command byte, status write and quad read phases.
    localparam logic [4:0] QADDR_CLKS = 5'h08;
    localparam logic [4:0] QDUMMY_CLKS = 5'h04;
    localparam logic [8:0] CONT_RESET_CLKS = 9'h008;
    localparam logic [8:0] BYTE_CLKS = 9'h008;
    localparam logic [8:0] WR_SR_CLKS = 9'h010;

    // Host serial clock half period and gap between frames, in mclk cycles.
    localparam logic [3:0] SCK_HALF = 4'h8;
    localparam logic [8:0] GAP_CYC = 9'h004;

    // Power-down exit wait: (count + 1) * unit.
    localparam int MCLK_PERIOD_NS = 10;
    localparam int PD_UNIT_NS = 1000;
    localparam logic [4:0] PD_DELAY_COUNT = 5'b00010;
    localparam logic [1:0] PD_DELAY_UNIT = 2'b01;
    localparam int PD_WAIT_NS = (int'(PD_DELAY_COUNT) + 1) * PD_UNIT_NS;
    localparam logic [8:0] PD_WAIT_CYC =
        9'((PD_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

    // Parameter word fields, low word first at its byte base.
    localparam logic [7:0] PARAM_W14_BASE = 8'h34;
    localparam logic [7:0] PARAM_W15_BASE = 8'h38;
    localparam logic [1:0] BUSY_POLL_LEGACY = 2'b01;
    localparam logic [2:0] QE_METHOD = 3'b101;
    localparam logic [3:0] MODE_ENTRY_METHOD = 4'b1001;
    localparam logic [5:0] MODE_EXIT_METHOD = 6'b111101;
    localparam logic [4:0] QPI_ENABLE_SEQ = 5'b00000;
    localparam logic [3:0] QPI_DISABLE_SEQ = 4'b0000;
    localparam logic [31:0] PARAM_W14 = {1'b0, CMD_PD_ENTER, CMD_PD_EXIT, PD_DELAY_UNIT,
        PD_DELAY_COUNT, 4'hf, BUSY_POLL_LEGACY, 2'h3};
    localparam logic [31:0] PARAM_W15 = {8'hff, 1'b0, QE_METHOD, MODE_ENTRY_METHOD,
        MODE_EXIT_METHOD, 1'b1, QPI_ENABLE_SEQ, QPI_DISABLE_SEQ};

    typedef enum logic [2:0] {
        OP_RD_SR1,
        OP_RD_SR2,
        OP_WR_SR,
        OP_QUAD_RD,
        OP_PD_EXIT,
        OP_CONT_RESET
    } sfq_op_e;

    // Byte of the two parameter words at a table address; other addresses read ff.
    function automatic logic [7:0] sfq_param_byte(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - PARAM_W14_BASE;
        if (addr >= PARAM_W14_BASE && addr < PARAM_W15_BASE) begin
            sfq_param_byte = PARAM_W14[off[1:0]*8 +: 8];
        end else if (addr >= PARAM_W15_BASE && addr < PARAM_W15_BASE + 8'h04) begin
            sfq_param_byte = PARAM_W15[off[1:0]*8 +: 8];
        end else begin
            sfq_param_byte = 8'hff;
        end
    endfunction : sfq_param_byte

endpackage : sfq_pkg

// ---- core/sfq_link_if.sv ----
interface sfq_link_if;
    logic sck;
    logic cs_n;
    logic [3:0] host_dq_o;
    logic [3:0] host_dq_oe;
    logic [3:0] dev_dq_o;
    logic [3:0] dev_dq_oe;
    logic [3:0] dq;

    // Each data line is pulled high when nobody drives it.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dev_dq_oe[i]) begin
                dq[i] = dev_dq_o[i];
            end else if (host_dq_oe[i]) begin
                dq[i] = host_dq_o[i];
            end else begin
                dq[i] = 1'b1;
            end
        end
    end

    modport host (output sck, output cs_n, output host_dq_o, output host_dq_oe, input dq);
    modport dev (input sck, input cs_n, input dq, output dev_dq_o, output dev_dq_oe);
endinterface : sfq_link_if

// ---- core/sfq_dev.sv ----
module sfq_dev
    import sfq_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    sfq_link_if.dev link,
    input wire logic write_busy_flag,
    output logic quad_io_enable_flag,
    output logic cont_mode,
    output logic [23:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] param_addr,
    output logic [7:0] param_data
);

    typedef enum logic [2:0] {
        D_CMD,
        D_RD,
        D_WR,
        D_QADDR,
        D_QDUMMY,
        D_QDATA,
        D_IGN
    } sfq_dstate_e;

    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_d_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic [3:0] dq_s1_r;
    logic [3:0] dq_s2_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            dq_s1_r <= 4'hf;
            dq_s2_r <= 4'hf;
        end else begin
            sck_s1_r <= link.sck;
            sck_s2_r <= sck_s1_r;
            sck_d_r <= sck_s2_r;
            cs_s1_r <= link.cs_n;
            cs_s2_r <= cs_s1_r;
            dq_s1_r <= link.dq;
            dq_s2_r <= dq_s1_r;
        end
    end

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_s2_r & ~sck_d_r;
    assign sck_fall = ~sck_s2_r & sck_d_r;

    sfq_dstate_e st_r;
    sfq_dstate_e st_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic qe_r;
    logic qe_nxt;
    logic cont_r;
    logic cont_nxt;
    logic a5_r;
    logic a5_nxt;
    logic mode_seen_r;
    logic mode_seen_nxt;
    logic half_r;
    logic half_nxt;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic [3:0] dout_r;
    logic [3:0] dout_nxt;
    logic [3:0] doe_r;
    logic [3:0] doe_nxt;
    logic [7:0] pdata_r;
    logic [7:0] pdata_nxt;

    always_comb begin
        logic [7:0] cmd;
        logic [31:0] word;
        cmd = {sh_r[6:0], dq_s2_r[0]};
        word = {sh_r[27:0], dq_s2_r};
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        qe_nxt = qe_r;
        cont_nxt = cont_r;
        a5_nxt = a5_r;
        mode_seen_nxt = mode_seen_r;
        half_nxt = half_r;
        addr_nxt = addr_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        pdata_nxt = sfq_param_byte(param_addr);
        if (cs_s2_r) begin
            st_nxt = cont_r ? D_QADDR : D_CMD;
            cnt_nxt = 5'h00;
            doe_nxt = 4'h0;
            half_nxt = 1'b0;
            if (mode_seen_r) begin
                cont_nxt = a5_r;
                mode_seen_nxt = 1'b0;
            end
        end else if (sck_rise) begin
            case (st_r)
                D_CMD: begin
                    sh_nxt = {sh_r[30:0], dq_s2_r[0]};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h07) begin
                        cnt_nxt = 5'h00;
                        case (cmd)
                            CMD_RD_SR1: begin
                                st_nxt = D_RD;
                                tx_nxt = 8'h00;
                                tx_nxt[SR1_BUSY_BIT] = write_busy_flag;
                            end
                            CMD_RD_SR2: begin
                                st_nxt = D_RD;
                                tx_nxt = 8'h00;
                                tx_nxt[SR2_QE_BIT] = qe_r;
                            end
                            CMD_WR_SR: begin
                                st_nxt = D_WR;
                            end
                            CMD_QUAD_RD: begin
                                st_nxt = qe_r ? D_QADDR : D_IGN;
                            end
                            default: begin
                                st_nxt = D_IGN;
                            end
                        endcase
                    end
                end
                D_WR: begin
                    sh_nxt = {sh_r[30:0], dq_s2_r[0]};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h0f) begin
                        qe_nxt = sh_r[0];
                        st_nxt = D_IGN;
                    end
                end
                D_QADDR: begin
                    sh_nxt = word;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == QADDR_CLKS - 5'h01) begin
                        cnt_nxt = 5'h00;
                        if (cont_r && word == 32'hffff_ffff) begin
                            cont_nxt = 1'b0;
                            st_nxt = D_IGN;
                        end else begin
                            addr_nxt = word[31:8];
                            a5_nxt = qe_r && (word[7:0] == MODE_ENTER);
                            mode_seen_nxt = 1'b1;
                            st_nxt = D_QDUMMY;
                        end
                    end
                end
                D_QDUMMY: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == QDUMMY_CLKS - 5'h01) begin
                        tx_nxt = rd_data;
                        addr_nxt = addr_r + 24'h000001;
                        half_nxt = 1'b0;
                        st_nxt = D_QDATA;
                    end
                end
                default: begin
                end
            endcase
        end else if (sck_fall) begin
            case (st_r)
                D_RD: begin
                    dout_nxt = {2'b00, tx_r[7], 1'b0};
                    doe_nxt = 4'h2;
                    tx_nxt = {tx_r[6:0], tx_r[7]};
                end
                D_QDATA: begin
                    doe_nxt = 4'hf;
                    half_nxt = ~half_r;
                    if (!half_r) begin
                        dout_nxt = tx_r[7:4];
                    end else begin
                        dout_nxt = tx_r[3:0];
                        tx_nxt = rd_data;
                        addr_nxt = addr_r + 24'h000001;
                    end
                end
                default: begin
                    doe_nxt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= D_CMD;
            cnt_r <= 5'h00;
            sh_r <= 32'h0000_0000;
            tx_r <= 8'h00;
            qe_r <= 1'b0;
            cont_r <= 1'b0;
            a5_r <= 1'b0;
            mode_seen_r <= 1'b0;
            half_r <= 1'b0;
            addr_r <= 24'h000000;
            dout_r <= 4'h0;
            doe_r <= 4'h0;
            pdata_r <= 8'hff;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            qe_r <= qe_nxt;
            cont_r <= cont_nxt;
            a5_r <= a5_nxt;
            mode_seen_r <= mode_seen_nxt;
            half_r <= half_nxt;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            pdata_r <= pdata_nxt;
        end
    end

    assign link.dev_dq_o = dout_r;
    assign link.dev_dq_oe = doe_r;
    assign quad_io_enable_flag = qe_r;
    assign cont_mode = cont_r;
    assign rd_addr = addr_r;
    assign param_data = pdata_r;

endmodule : sfq_dev

// ---- core/sfq_host.sv ----
module sfq_host
    import sfq_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    sfq_link_if.host link,
    input wire logic cmd_valid,
    input wire sfq_op_e cmd_op,
    input wire logic [15:0] cmd_wdata,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_mode,
    input wire logic [7:0] cmd_len,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic dev_busy,
    output logic qe_known,
    output logic cont_mode
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_CMD,
        H_TX,
        H_DUMMY,
        H_RX,
        H_WAIT
    } sfq_hstate_e;

    logic [3:0] dq_s1_r;
    logic [3:0] dq_s2_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dq_s1_r <= 4'hf;
            dq_s2_r <= 4'hf;
        end else begin
            dq_s1_r <= link.dq;
            dq_s2_r <= dq_s1_r;
        end
    end

    sfq_hstate_e st_r, st_nxt;
    sfq_op_e op_r, op_nxt;
    logic [3:0] div_r, div_nxt;
    logic sck_r, sck_nxt;
    logic cs_n_r, cs_n_nxt;
    logic quad_r, quad_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [2:0] rxc_r, rxc_nxt;
    logic [3:0] dout_r, dout_nxt;
    logic [3:0] doe_r, doe_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [31:0] qword_r, qword_nxt;
    logic [7:0] len_r, len_nxt;
    logic [8:0] wait_r, wait_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [7:0] rsp_data_r, rsp_data_nxt;
    logic busy_r, busy_nxt;
    logic qe_r, qe_nxt;
    logic cont_r, cont_nxt;

    always_comb begin
        logic [7:0] rxb;
        rxb = quad_r ? {rx_r[3:0], dq_s2_r} : {rx_r[6:0], dq_s2_r[1]};
        st_nxt = st_r;
        op_nxt = op_r;
        div_nxt = div_r;
        sck_nxt = sck_r;
        cs_n_nxt = cs_n_r;
        quad_nxt = quad_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        rxc_nxt = rxc_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        wdata_nxt = wdata_r;
        qword_nxt = qword_r;
        len_nxt = len_r;
        wait_nxt = wait_r;
        ready_nxt = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        busy_nxt = busy_r;
        qe_nxt = qe_r;
        cont_nxt = cont_r;
        case (st_r)
            H_IDLE: begin
                // quad read refused until flag set
                if (cmd_valid && ready_r && !(cmd_op == OP_QUAD_RD && !qe_r)) begin
                    op_nxt = cmd_op;
                    ready_nxt = 1'b0;
                    cs_n_nxt = 1'b0;
                    div_nxt = 4'h0;
                    rxc_nxt = 3'h0;
                    wdata_nxt = cmd_wdata;
                    qword_nxt = {cmd_addr, cmd_mode};
                    len_nxt = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                    if (cmd_op == OP_CONT_RESET || (cmd_op == OP_QUAD_RD && cont_r)) begin
                        st_nxt = H_TX;
                        quad_nxt = 1'b1;
                        sh_nxt = (cmd_op == OP_CONT_RESET) ? 32'hffff_ffff : {cmd_addr, cmd_mode};
                        cnt_nxt = CONT_RESET_CLKS;
                        dout_nxt = sh_nxt[31:28];
                        doe_nxt = 4'hf;
                    end else begin
                        st_nxt = H_CMD;
                        quad_nxt = 1'b0;
                        case (cmd_op)
                            OP_RD_SR1: sh_nxt = {CMD_RD_SR1, 24'h000000};
                            OP_RD_SR2: sh_nxt = {CMD_RD_SR2, 24'h000000};
                            OP_WR_SR: sh_nxt = {CMD_WR_SR, 24'h000000};
                            OP_QUAD_RD: sh_nxt = {CMD_QUAD_RD, 24'h000000};
                            default: sh_nxt = {CMD_PD_EXIT, 24'h000000};
                        endcase
                        cnt_nxt = BYTE_CLKS;
                        dout_nxt = {3'b000, sh_nxt[31]};
                        doe_nxt = 4'h1;
                    end
                end
            end
            H_WAIT: begin
                wait_nxt = wait_r - 9'h001;
                if (wait_r == 9'h001) begin
                    st_nxt = H_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            default: begin
                div_nxt = div_r + 4'h1;
                if (div_r == SCK_HALF - 4'h1) begin
                    div_nxt = 4'h0;
                    sck_nxt = ~sck_r;
                    if (!sck_r) begin
                        cnt_nxt = cnt_r - 9'h001;
                        if (st_r == H_RX) begin
                            rx_nxt = rxb;
                            rxc_nxt = rxc_r + 3'h1;
                            if ((quad_r && rxc_r[0]) || (!quad_r && rxc_r == 3'h7)) begin
                                rsp_valid_nxt = 1'b1;
                                rsp_data_nxt = rxb;
                                if (op_r == OP_RD_SR1) begin
                                    busy_nxt = rxb[SR1_BUSY_BIT];
                                end
                            end
                        end
                    end else if (cnt_r != 9'h000) begin
                        sh_nxt = quad_r ? {sh_r[27:0], 4'hf} : {sh_r[30:0], 1'b0};
                        dout_nxt = quad_r ? sh_nxt[31:28] : {3'b000, sh_nxt[31]};
                    end else begin
                        doe_nxt = 4'h0;
                        if (st_r == H_CMD && op_r == OP_WR_SR) begin
                            st_nxt = H_TX;
                            sh_nxt = {wdata_r, 16'h0000};
                            cnt_nxt = WR_SR_CLKS;
                            dout_nxt = {3'b000, wdata_r[15]};
                            doe_nxt = 4'h1;
                        end else if (st_r == H_CMD && op_r == OP_QUAD_RD) begin
                            st_nxt = H_TX;
                            quad_nxt = 1'b1;
                            sh_nxt = qword_r;
                            cnt_nxt = {4'h0, QADDR_CLKS};
                            dout_nxt = qword_r[31:28];
                            doe_nxt = 4'hf;
                        end else if (st_r == H_CMD && op_r != OP_PD_EXIT) begin
                            st_nxt = H_RX;
                            cnt_nxt = BYTE_CLKS;
                        end else if (st_r == H_TX && op_r == OP_QUAD_RD) begin
                            st_nxt = H_DUMMY;
                            cnt_nxt = {4'h0, QDUMMY_CLKS};
                        end else if (st_r == H_DUMMY) begin
                            st_nxt = H_RX;
                            cnt_nxt = {len_r, 1'b0};
                        end else begin
                            st_nxt = H_WAIT;
                            cs_n_nxt = 1'b1;
                            wait_nxt = (op_r == OP_PD_EXIT) ? PD_WAIT_CYC : GAP_CYC;
                            if (op_r == OP_WR_SR) begin
                                qe_nxt = wdata_r[SR2_QE_BIT];
                            end
                            if (op_r == OP_QUAD_RD) begin
                                cont_nxt = (qword_r[7:0] == MODE_ENTER);
                            end
                            if (op_r == OP_CONT_RESET) begin
                                cont_nxt = 1'b0;
                            end
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= H_IDLE;
            op_r <= OP_RD_SR1;
            div_r <= 4'h0;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            quad_r <= 1'b0;
            sh_r <= 32'h0000_0000;
            cnt_r <= 9'h000;
            rx_r <= 8'h00;
            rxc_r <= 3'h0;
            dout_r <= 4'h0;
            doe_r <= 4'h0;
            wdata_r <= 16'h0000;
            qword_r <= 32'h0000_0000;
            len_r <= 8'h01;
            wait_r <= 9'h000;
            ready_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            busy_r <= 1'b0;
            qe_r <= 1'b0;
            cont_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            div_r <= div_nxt;
            sck_r <= sck_nxt;
            cs_n_r <= cs_n_nxt;
            quad_r <= quad_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            rxc_r <= rxc_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            wdata_r <= wdata_nxt;
            qword_r <= qword_nxt;
            len_r <= len_nxt;
            wait_r <= wait_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            busy_r <= busy_nxt;
            qe_r <= qe_nxt;
            cont_r <= cont_nxt;
        end
    end

    assign link.sck = sck_r;
    assign link.cs_n = cs_n_r;
    assign link.host_dq_o = dout_r;
    assign link.host_dq_oe = doe_r;
    assign cmd_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;
    assign dev_busy = busy_r;
    assign qe_known = qe_r;
    assign cont_mode = cont_r;

endmodule : sfq_host

// ---- verification/sfq_properties.sv ----
module sfq_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] host_dq_o,
    input wire logic [3:0] host_dq_oe,
    input wire logic [3:0] dev_dq_o,
    input wire logic [3:0] dev_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_idle_clock_low: assert property (cs_n |-> !sck) else $error("clock outside frame");
    // The device sees the select through two flip-flops, so its drive may outlast it by three.
    a_idle_no_drive: assert property (cs_n && $past(cs_n, 3) |-> dev_dq_oe == 4'h0)
        else $error("idle drive");
    a_no_contention: assert property ((dev_dq_oe & host_dq_oe) == 4'h0) else $error("clash");
    a_reply_lanes: assert property (dev_dq_oe inside {4'h0, 4'h2, 4'hf}) else $error("lanes");
    a_high_half: assert property ($rose(sck) |-> sck[*8]) else $error("short high half");
    a_first_rise: assert property ($fell(cs_n) |-> (!sck)[*8]) else $error("early clock");
    a_host_held: assert property (sck && $past(sck) |-> $stable(host_dq_o & host_dq_oe))
        else $error("host data moved");
    a_dev_held: assert property (sck && $past(sck) |-> $stable(dev_dq_o & dev_dq_oe))
        else $error("device data moved");
    c_status_reply: cover property ($rose(dev_dq_oe[1]));
    c_quad_reply: cover property ($rose(&dev_dq_oe));
    c_frame: cover property ($fell(cs_n));
endmodule : sfq_checker

// ---- verification/sfq_quad_mode_params_bench.sv ----
module sfq_quad_mode_params_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfq_pkg::*;
    logic mclk, nrst, write_busy_flag, quad_io_enable_flag, dev_cont, cmd_valid, cmd_ready;
    logic rsp_valid, dev_busy, qe_known, host_cont;
    logic [23:0] rd_addr, cmd_addr;
    logic [15:0] cmd_wdata;
    logic [7:0] rd_data, param_addr, param_data, cmd_mode, cmd_len, rsp_data, last_rsp;
    sfq_op_e cmd_op;
    int errors, n_checks, gap;
    logic [71:0] tbl = 72'hff_ff_59_f6_00_5c_d5_a2_f7;
    sfq_link_if link ();
    sfq_dev sfq_dev_i (.mclk, .nrst, .link, .write_busy_flag, .quad_io_enable_flag,
        .cont_mode(dev_cont), .rd_addr, .rd_data, .param_addr, .param_data);
    sfq_host sfq_host_i (.mclk, .nrst, .link, .cmd_valid, .cmd_op, .cmd_wdata, .cmd_addr,
        .cmd_mode, .cmd_len, .cmd_ready, .rsp_valid, .rsp_data, .dev_busy, .qe_known,
        .cont_mode(host_cont));
    sfq_checker sfq_checker_i (.mclk, .nrst, .sck(link.sck), .cs_n(link.cs_n),
        .host_dq_o(link.host_dq_o), .host_dq_oe(link.host_dq_oe), .dev_dq_o(link.dev_dq_o),
        .dev_dq_oe(link.dev_dq_oe));
    // Array stand-in: each byte is its low address bits scrambled.
    assign rd_data = rd_addr[7:0] ^ 8'h5a;
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (rsp_valid) last_rsp <= rsp_data;
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Counts idle-bus cycles in gap while waiting for the host to go ready.
    task automatic idle();
        int t;
        t = 0;
        while (cmd_ready !== 1'b1) begin
            @(negedge mclk);
            gap += int'(link.cs_n === 1'b1);
            t++;
            if (t > 3000) begin
                errors++;
                $display("Error at %0t: got %h expected %h", $time, cmd_ready, 1'b1);
                conclude();
            end
        end
    endtask : idle
    task automatic run(input sfq_op_e op, input logic [15:0] wd, input logic [7:0] md);
        idle();
        @(posedge mclk);
        cmd_op <= op;
        cmd_wdata <= wd;
        cmd_mode <= md;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        repeat (2) @(negedge mclk);
        gap = 0;
        idle();
    endtask : run
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_RD_SR1;
        cmd_wdata = 16'h0000;
        cmd_addr = 24'h000123;
        cmd_mode = 8'h00;
        cmd_len = 8'h00;
        write_busy_flag = 1'b1;
        param_addr = 8'h34;
        errors = 0;
        n_checks = 0;
        gap = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            param_addr <= 8'h34 + 8'(i);
            @(posedge mclk);
            @(negedge mclk);
            chk(param_data, tbl[i*8 +: 8]);
            @(posedge mclk);
        end
        run(OP_RD_SR1, 16'h0000, 8'h00);
        chk(8'(last_rsp[0] & dev_busy), 8'h01);
        @(posedge mclk);
        write_busy_flag <= 1'b0;
        run(OP_RD_SR1, 16'h0000, 8'h00);
        chk(8'(last_rsp[0] | dev_busy), 8'h00);
        run(OP_WR_SR, 16'h0002, 8'h00);
        chk(8'(quad_io_enable_flag & qe_known), 8'h01);
        run(OP_RD_SR2, 16'h0000, 8'h00);
        chk(last_rsp, 8'h02);
        run(OP_QUAD_RD, 16'h0000, 8'ha5);
        chk(last_rsp, 8'h79);
        chk(8'(dev_cont & host_cont), 8'h01);
        run(OP_QUAD_RD, 16'h0000, 8'h00);
        chk(last_rsp, 8'h79);
        chk(8'(dev_cont | host_cont), 8'h00);
        run(OP_QUAD_RD, 16'h0000, 8'ha5);
        chk(8'(dev_cont & host_cont), 8'h01);
        run(OP_CONT_RESET, 16'h0000, 8'h00);
        chk(8'(dev_cont | host_cont), 8'h00);
        run(OP_WR_SR, 16'hff00, 8'h00);
        chk(8'(quad_io_enable_flag | qe_known), 8'h00);
        run(OP_QUAD_RD, 16'h0000, 8'ha5);
        chk(8'(dev_cont), 8'h00);
        run(OP_PD_EXIT, 16'h0000, 8'h00);
        chk(8'(gap >= int'(PD_WAIT_CYC)), 8'h01);
        conclude();
    end
endmodule : sfq_quad_mode_params_bench
